// ### rtl/srmp_packetizer.sv
`timescale 1ns/1ps
module srmp_packetizer #(
    parameter int IDLE_COUNT = srmp_pkg::IDLE_CYCLES,
    parameter int REPORT_COUNT = srmp_pkg::REPORT_CYCLES,
    parameter int DEPTH = srmp_pkg::BUFFER_BYTES,
    parameter int PKT = srmp_pkg::PACKET_BYTES
) (
    input wire logic clk, // 100 MHz
    input wire logic reset, // synchronous, high
    input wire logic modeSelectLow, // pin, async
    input wire logic modeSelectHigh, // pin, async
    input wire logic [15:0] ownAddr, // configured address
    input wire logic serValid, // received serial byte
    input wire logic [7:0] serData, // its value
    output logic [7:0] txData, // byte to radio
    output logic txValid, // byte to radio valid
    input wire logic txReady, // radio accepts byte
    output logic txLast, // last byte of packet
    output logic [15:0] txDestAddr, // packet destination
    input wire logic rxValid, // radio packet byte
    input wire logic [7:0] rxData, // its value
    input wire logic [15:0] rxDestAddr, // its destination
    input wire logic [7:0] rssiLevel, // measured strength
    output logic [7:0] outData, // byte to serial
    output logic outValid, // byte to serial valid
    output logic [7:0] cfgData, // command byte
    output logic cfgValid, // command byte valid
    output srmp_pkg::srmp_mode_e mode, // current mode
    output logic radioEnable, // radio powered
    output logic serialEnable, // serial powered
    output logic fixedBaud, // force 9600 8N1
    output logic overflow // pulse, data lost
);
    import srmp_pkg::*;

    // ***************************************************
    // mode select
    // ***************************************************
    logic [1:0] selMeta;
    logic [1:0] selSync;
    // two-stage synchroniser on select pins
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            selMeta <= 2'h0;
            selSync <= 2'h0;
        end
        else
        begin
            selMeta <= {modeSelectHigh, modeSelectLow};
            selSync <= selMeta;
        end
    end
    // mode follows the pins every cycle; only a pin change leaves sleep
    always_ff @(posedge clk)
    begin
        if (reset)
            mode <= SRMP_TRANSPARENT;
        else
            mode <= srmp_mode_e'(selSync);
    end
    logic isT;
    assign isT = (mode == SRMP_TRANSPARENT);
    // power and format controls per mode
    assign radioEnable = isT;
    assign serialEnable = (mode != SRMP_SLEEP);
    assign fixedBaud = (mode == SRMP_CONFIG);

    // ***************************************************
    // serial buffer
    // ***************************************************
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic [AW:0] pktLeft;
    logic [31:0] idleCnt;
    logic pushOk;
    logic pop;
    logic launch;
    logic sending;
    assign pushOk = isT && serValid;
    assign pop = sending && txReady && (count != '0);
    assign launch = isT && !sending && (count != '0)
        && ((count >= (AW+1)'(PKT)) || (idleCnt >= IDLE_COUNT - 1));
    // storage write
    always_ff @(posedge clk)
    begin
        if (pushOk)
            mem[wrPtr] <= serData;
    end
    // pointers and fill; overflow flushes everything
    always_ff @(posedge clk)
    begin
        if (reset || !isT)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            overflow <= 1'b0;
        end
        else if (pushOk && count == (AW+1)'(DEPTH))
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            overflow <= 1'b1;
        end
        else
        begin
            overflow <= 1'b0;
            if (pushOk)
                wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            if (pop)
                rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            count <= count + (AW+1)'(pushOk) - (AW+1)'(pop);
        end
    end
    // idle timer restarts per byte and clears on launch
    always_ff @(posedge clk)
    begin
        if (reset || serValid || launch || !isT)
            idleCnt <= '0;
        else if (idleCnt < IDLE_COUNT)
            idleCnt <= idleCnt + 1;
    end

    // ***************************************************
    // packet launch
    // ***************************************************
    // one packet at a time, up to PKT bytes, then next
    always_ff @(posedge clk)
    begin
        if (reset || !isT || overflow)
        begin
            sending <= 1'b0;
            pktLeft <= '0;
        end
        else if (launch)
        begin
            sending <= 1'b1;
            pktLeft <= (count > (AW+1)'(PKT)) ? (AW+1)'(PKT) : count;
        end
        else if (pop)
        begin
            pktLeft <= pktLeft - 1'b1;
            if (pktLeft == (AW+1)'(1))
                sending <= 1'b0;
        end
    end
    assign txValid = sending && (count != '0) && isT;
    assign txData = mem[rdPtr];
    assign txLast = (pktLeft == (AW+1)'(1));
    assign txDestAddr = ownAddr;

    // ***************************************************
    // serial output, radio receive and strength report
    // ***************************************************
    logic [31:0] rptCnt;
    logic rptTick;
    logic rxAccept;
    assign rptTick = (mode == SRMP_STRENGTH) && (rptCnt == REPORT_COUNT - 1);
    assign rxAccept = isT && rxValid
        && (ownAddr == BROADCAST_ADDR || rxDestAddr == ownAddr);
    // report divider in strength mode
    always_ff @(posedge clk)
    begin
        if (reset || mode != SRMP_STRENGTH || rptTick)
            rptCnt <= '0;
        else
            rptCnt <= rptCnt + 1;
    end
    // registered serial output
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            outValid <= 1'b0;
            outData <= 8'h00;
        end
        else
        begin
            outValid <= rptTick || rxAccept;
            if (rptTick)
                outData <= rssiLevel;
            else if (rxAccept)
                outData <= rxData;
        end
    end
    // configuration bytes passed on only in mode two
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cfgValid <= 1'b0;
            cfgData <= 8'h00;
        end
        else
        begin
            cfgValid <= (mode == SRMP_CONFIG) && serValid;
            cfgData <= serData;
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    property p_noTxOff;
        @(posedge clk) disable iff (reset) !isT |-> !txValid;
    endproperty
    a_noTxOff: assert property (p_noTxOff) else $error("radio tx outside mode 0");
    property p_reset0;
        @(posedge clk) $fell(reset) |-> mode == SRMP_TRANSPARENT;
    endproperty
    a_reset0: assert property (p_reset0) else $error("mode not 0 after reset");
    property p_follow;
        @(posedge clk) disable iff (reset)
            ##2 1'b1 |-> mode == srmp_mode_e'($past({modeSelectHigh, modeSelectLow}, 3));
    endproperty
    a_follow: assert property (p_follow) else $error("mode not following select");
    property p_sleepPwr;
        @(posedge clk) disable iff (reset) mode == SRMP_SLEEP |-> !serialEnable && !radioEnable;
    endproperty
    a_sleepPwr: assert property (p_sleepPwr) else $error("sleep left powered");
    property p_baud;
        @(posedge clk) disable iff (reset) fixedBaud == (mode == SRMP_CONFIG);
    endproperty
    a_baud: assert property (p_baud) else $error("fixed baud wrong");
    property p_full;
        @(posedge clk) disable iff (reset)
            isT && !sending && count >= (AW+1)'(PKT) |=> sending;
    endproperty
    a_full: assert property (p_full) else $error("full packet not launched");
    property p_pktMax;
        @(posedge clk) disable iff (reset) pktLeft <= (AW+1)'(PKT);
    endproperty
    a_pktMax: assert property (p_pktMax) else $error("packet too long");
    property p_ovf;
        @(posedge clk) disable iff (reset)
            pushOk && count == (AW+1)'(DEPTH) |=> count == '0 && overflow;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow did not flush");
    property p_rxMode;
        @(posedge clk) disable iff (reset) rxValid && !isT |=> !outValid || $past(rptTick);
    endproperty
    a_rxMode: assert property (p_rxMode) else $error("rx delivered outside mode 0");
    // mode decode and power per mode
    property p_modeZero;
        @(posedge clk) disable iff (reset) srmp_mode_e'(selSync) == SRMP_TRANSPARENT
            |=> isT && radioEnable && serialEnable;
    endproperty
    a_modeZero: assert property (p_modeZero) else $error("selects low, not transparent");
    property p_strength;
        @(posedge clk) disable iff (reset)
            mode == SRMP_STRENGTH |-> !radioEnable && serialEnable;
    endproperty
    a_strength: assert property (p_strength) else $error("strength mode power wrong");
    property p_sleepHold;
        @(posedge clk) disable iff (reset)
            mode == SRMP_SLEEP && srmp_mode_e'(selSync) == SRMP_SLEEP |=> mode == SRMP_SLEEP;
    endproperty
    a_sleepHold: assert property (p_sleepHold) else $error("sleep left on its own");
    // buffering, idle timer and packet boundaries
    property p_dropOff;
        @(posedge clk) disable iff (reset) !isT |=> count == '0;
    endproperty
    a_dropOff: assert property (p_dropOff) else $error("serial bytes kept off mode 0");
    property p_idleRestart;
        @(posedge clk) disable iff (reset) serValid || launch |=> idleCnt == '0;
    endproperty
    a_idleRestart: assert property (p_idleRestart) else $error("idle timer not restarted");
    property p_noEarly;
        @(posedge clk) disable iff (reset) isT && !sending && count < (AW+1)'(PKT)
            && idleCnt < IDLE_COUNT - 1 |=> !sending;
    endproperty
    a_noEarly: assert property (p_noEarly) else $error("short packet launched early");
    property p_idleLaunch;
        @(posedge clk) disable iff (reset) isT && !sending && count != '0
            && idleCnt >= IDLE_COUNT - 1 |=> sending;
    endproperty
    a_idleLaunch: assert property (p_idleLaunch) else $error("idle packet not launched");
    property p_lastEnds;
        @(posedge clk) disable iff (reset) pop && txLast |=> !sending;
    endproperty
    a_lastEnds: assert property (p_lastEnds) else $error("packet ran past last byte");
    // serial side: commands, reports and radio delivery
    property p_cfgEcho;
        @(posedge clk) disable iff (reset)
            mode == SRMP_CONFIG && serValid |=> cfgValid && cfgData == $past(serData);
    endproperty
    a_cfgEcho: assert property (p_cfgEcho) else $error("command byte not passed on");
    property p_cfgOff;
        @(posedge clk) disable iff (reset) mode != SRMP_CONFIG |=> !cfgValid;
    endproperty
    a_cfgOff: assert property (p_cfgOff) else $error("command byte outside mode 2");
    property p_report;
        @(posedge clk) disable iff (reset) rptTick |=> outValid && outData == $past(rssiLevel);
    endproperty
    a_report: assert property (p_report) else $error("strength report missing");
    property p_rxAll;
        @(posedge clk) disable iff (reset) isT && rxValid && ownAddr == BROADCAST_ADDR
            |=> outValid && outData == $past(rxData);
    endproperty
    a_rxAll: assert property (p_rxAll) else $error("monitor address missed a byte");
    property p_rxOwn;
        @(posedge clk) disable iff (reset) isT && rxValid && rxDestAddr == ownAddr |=> outValid;
    endproperty
    a_rxOwn: assert property (p_rxOwn) else $error("own packet not delivered");
    c_launch: cover property (@(posedge clk) launch && count < (AW+1)'(PKT));
    c_full: cover property (@(posedge clk) launch && count >= (AW+1)'(PKT));
    c_report: cover property (@(posedge clk) rptTick);
    c_ovf: cover property (@(posedge clk) overflow);
    c_sleep: cover property (@(posedge clk) mode == SRMP_SLEEP && serValid);
endmodule

// ### shared/srmp_pkg.sv
// How it works
// - both selects low: transparent mode zero
// - reset starts in transparent mode zero
// - low select only: signal-strength mode one
// - mode one: no radio, serial bytes dropped
// - mode one: strength byte every 100ms
// - high select only: configuration mode two
// - mode two: radio off, commands only
// - mode two: serial fixed 9600 8N1
// - both selects high: sleep mode three
// - only select change leaves sleep
// - 54 bytes pending launches a packet
// - 20ms serial idle launches short packet
// - long input split into consecutive packets
// - over 500 bytes drops all pending
// - accept radio packets only in mode zero
// - broadcast address sent to all listeners; rx here drops such packets unless ownAddr is broadcast too
// - broadcast address receives every packet
// - mode change applies three clocks after the pins, kept held
package srmp_pkg;
    // ***************************************************
    // modes and timing
    // ***************************************************
    typedef enum logic [1:0] {
        SRMP_TRANSPARENT,
        SRMP_STRENGTH,
        SRMP_CONFIG,
        SRMP_SLEEP
    } srmp_mode_e;
    localparam int CLK_HZ = 100_000_000;
    localparam int IDLE_MS = 20;
    localparam int REPORT_MS = 100;
    localparam int IDLE_CYCLES = CLK_HZ / 1000 * IDLE_MS;
    localparam int REPORT_CYCLES = CLK_HZ / 1000 * REPORT_MS;
    localparam int PACKET_BYTES = 54;
    localparam int BUFFER_BYTES = 500;
    localparam int CONFIG_BAUD = 9600;
    localparam logic [15:0] BROADCAST_ADDR = 16'hffff;
endpackage

// ### testbench/serial_radio_mode_packetizer_tb.sv
`timescale 1ns/1ps
module serial_radio_mode_packetizer_tb;
    import srmp_pkg::*;
    logic clk = 1'b0, reset = 1'b1, modeSelectLow = 1'b0, modeSelectHigh = 1'b0;
    logic txReady = 1'b1, rxValid = 1'b0, serValid, txValid, txLast, outValid, cfgValid;
    logic radioEnable, serialEnable, fixedBaud, overflow;
    logic [15:0] ownAddr = 16'h1234, rxDestAddr = 16'h0000, txDestAddr;
    logic [7:0] rxData = 8'h00, rssiLevel = 8'h00, serData, txData, outData, cfgData;
    srmp_mode_e mode;
    int fails = 0, compares = 0, cycles = 0, nOut = 0, nCfg = 0, nOvf = 0, nLast = 0, firstLen;
    logic [7:0] txQ[$], lastOut, lastCfg;
    // ***************************************************
    // design, host and monitor
    // ***************************************************
    srmp_packetizer #(.IDLE_COUNT(50), .REPORT_COUNT(100)) srmp_packetizer_inst (.clk, .reset,
        .modeSelectLow, .modeSelectHigh, .ownAddr, .serValid, .serData, .txData, .txValid,
        .txReady, .txLast, .txDestAddr, .rxValid, .rxData, .rxDestAddr, .rssiLevel, .outData,
        .outValid, .cfgData, .cfgValid, .mode, .radioEnable, .serialEnable, .fixedBaud,
        .overflow);
    srmp_host_model srmp_host_model_inst (.clk, .serValid, .serData);
    always #5 clk = ~clk;
    // record every output event and cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (txValid === 1'b1 && txReady)
        begin
            txQ.push_back(txData);
            if (txLast === 1'b1 && nLast++ == 0) firstLen = txQ.size();
        end
        if (outValid === 1'b1)
        begin
            nOut++;
            lastOut = outData;
        end
        if (cfgValid === 1'b1)
        begin
            nCfg++;
            lastCfg = cfgData;
        end
        if (overflow === 1'b1)
            nOvf++;
        if (cycles == 20000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    // ***************************************************
    // helpers
    // ***************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkNum(input int got, input int exp);
        compares++;
        if (got != exp)
        begin
            fails++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    // radio, serial, fixed-baud levels per mode
    function automatic logic [7:0] expCtl(input logic [1:0] m);
        return (m == 2'd0) ? 8'h06 : (m == 2'd1) ? 8'h02 : (m == 2'd2) ? 8'h03 : 8'h00;
    endfunction
    task automatic setMode(input logic [1:0] m);
        @(negedge clk);
        modeSelectLow = m[0];
        modeSelectHigh = m[1];
        repeat (4) @(negedge clk);
    endtask
    task automatic rxByte(input logic [15:0] dest);
        @(negedge clk);
        rxValid = 1'b1;
        rxData = 8'($urandom);
        rxDestAddr = dest;
        @(negedge clk);
        rxValid = 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ***************************************************
    // scenarios
    // ***************************************************
    initial
    begin
        logic [7:0] q[$];
        void'($urandom(32'h40ef));
        repeat (16) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk({6'h00, mode}, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            setMode(m[1:0]);
            chk({6'h00, mode}, m[7:0]);
            chk({5'h00, radioEnable, serialEnable, fixedBaud}, expCtl(m[1:0]));
        end
        // transparent: 60 bytes become one full and one idle-ended packet
        setMode(2'd0);
        repeat (60) q.push_back(8'($urandom));
        txQ.delete();
        nLast = 0;
        srmp_host_model_inst.sendBytes(q);
        // launched on the 54th byte, one byte a cycle since, input still flowing
        repeat (10) @(negedge clk);
        chkNum(txQ.size(), 15);
        for (int i = 0; i < 300 && txQ.size() < 60; i++) @(negedge clk);
        chkNum(txQ.size(), 60);
        chkNum(firstLen, PACKET_BYTES);
        chkNum(nLast, 2);
        foreach (q[i]) chk(txQ[i], q[i]);
        chk({7'h00, txDestAddr === ownAddr}, 8'h01);
        // a short burst waits for the idle time, then goes out whole
        txQ.delete();
        srmp_host_model_inst.sendBytes(q[0:4]);
        repeat (40) @(negedge clk);
        chkNum(txQ.size(), 0);
        repeat (20) @(negedge clk);
        chkNum(txQ.size(), 5);
        chk(txQ[4], q[4]);
        // radio receive: matching, foreign and monitor address
        nOut = 0;
        rxByte(16'h1234);
        chkNum(nOut, 1);
        chk(lastOut, rxData);
        rxByte(16'h5678);
        chkNum(nOut, 1);
        ownAddr = 16'hffff;
        rxByte(16'h5678);
        chkNum(nOut, 2);
        // strength mode: no radio, periodic level
        rssiLevel = 8'($urandom);
        setMode(2'd1);
        nOut = 0;
        txQ.delete();
        srmp_host_model_inst.sendBytes(q[0:4]);
        for (int i = 0; i < 150 && nOut == 0; i++) @(negedge clk);
        chk(lastOut, rssiLevel);
        // one report per period and nothing on the radio
        nOut = 0;
        repeat (150) @(negedge clk);
        chkNum(nOut, 1);
        chkNum(txQ.size(), 0);
        // configuration mode: command bytes only
        setMode(2'd2);
        nOut = 0;
        srmp_host_model_inst.sendBytes({8'hc1});
        @(negedge clk);
        chkNum(nCfg, 1);
        chk(lastCfg, 8'hc1);
        rxByte(16'h1234);
        chkNum(nOut, 0);
        // sleep: nothing wakes it but the pins
        setMode(2'd3);
        nCfg = 0;
        srmp_host_model_inst.sendBytes(q[0:2]);
        rxByte(16'h1234);
        chk({6'h00, mode}, 8'h03);
        chkNum(nOut + nCfg + txQ.size(), 0);
        setMode(2'd0);
        chk({6'h00, mode}, 8'h00);
        // overflow with the radio stalled
        txReady = 1'b0;
        while (q.size() <= BUFFER_BYTES) q.push_back(8'($urandom));
        srmp_host_model_inst.sendBytes(q);
        repeat (3) @(negedge clk);
        chkNum(nOvf, 1);
        // the flushed bytes never reach the radio
        txReady = 1'b1;
        repeat (80) @(negedge clk);
        chkNum(txQ.size(), 0);
        tally_and_finish();
    end
endmodule

// ### testbench/srmp_host_model.sv
`timescale 1ns/1ps
// ***************************************************
// serial host: one byte per clock, changed at the falling edge
// ***************************************************
module srmp_host_model (
    input wire logic clk, // bench clock
    output logic serValid, // byte strobe
    output logic [7:0] serData // byte value
);
    // back-to-back bytes; a released line flips so no stale byte shows
    task automatic sendBytes(input logic [7:0] b[$]);
        foreach (b[i])
        begin
            @(negedge clk);
            serValid = 1'b1;
            serData = b[i];
        end
        @(negedge clk);
        serValid = 1'b0;
        serData = ~serData;
    endtask
    initial
    begin
        serValid = 1'b0;
        serData = 8'h00;
    end
endmodule
